// ---- shared/pin_mux_pkg.sv ----
/*
 pin_mux_pkg: register map, field masks, pin function tables and
 carrier structs for the pin function mux.
 assumes an APB master with 32-bit data and a 12-bit byte address.
*/
package pin_mux_pkg;
  localparam int ADDR_W = 12;
  typedef logic [ADDR_W-1:0] addr_t;

  // ****************************************
  // register byte addresses
  // ****************************************
  localparam addr_t A_E_DRIVE = 12'h000;
  localparam addr_t A_G_DRIVE = 12'h004;
  localparam addr_t A_PAD_SUP = 12'h008;
  localparam addr_t A_SEL_A_LO = 12'h00c;
  localparam addr_t A_SEL_A_HI = 12'h010;
  localparam addr_t A_SEL_B_LO = 12'h014;
  localparam addr_t A_SEL_B_HI = 12'h018;
  localparam addr_t A_SEL_C_LO = 12'h01c;
  localparam addr_t A_OWNER = 12'h020;

  // ****************************************
  // masks, reset value, field positions
  // ****************************************
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] M_FULL = 8'hff;
  localparam logic [7:0] M_E_DRIVE = 8'h03;
  localparam logic [7:0] M_G_DRIVE = 8'h0f;
  localparam logic [7:0] M_PAD_SUP = 8'h3f;
  localparam logic [7:0] M_SEL_C_LO = 8'h0f;
  localparam int PAD_B_LO_UP = 1;
  localparam int PAD_B_HI_UP = 3;
  localparam int PAD_G_UP = 5;

  // ****************************************
  // pin function kinds, two bits per code
  // ****************************************
  localparam logic [1:0] K_GPIO = 2'h0;
  localparam logic [1:0] K_PER = 2'h1;
  localparam logic [1:0] K_REL = 2'h2;
  typedef logic [7:0] kinds_t;
  localparam kinds_t KIND_A [8] = '{8'h90, 8'ha4, 8'h80, 8'ha0,
                                    8'ha0, 8'h90, 8'ha4, 8'h80};
  localparam kinds_t KIND_B [8] = '{8'h94, 8'h94, 8'h90, 8'h90,
                                    8'h40, 8'h40, 8'h40, 8'h80};
  localparam kinds_t KIND_C [2] = '{8'h90, 8'h80};

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    addr_t paddr;
    logic [31:0] pwdata;
    logic [3:0] pstrb;
  } apb_req_s;

  typedef struct packed {
    logic periodic_timer0_inverted_out;
    logic periodic_timer0_out;
    logic periodic_timer1_out;
    logic periodic_timer2_out;
    logic std_timer_inverted_out;
    logic serial_chip_select;
    logic serial_data_out;
    logic serial_sda_out;
    logic serial_clock_out;
    logic second_spi_clock;
    logic second_spi_data_out;
    logic second_spi_chip_select;
  } periph_out_s;
endpackage

// ---- src/pin_function_mux.sv ----
/*
 pin_function_mux: drive level, pad supply and output function
 selection for ports A, B and pins 0..1 of port C, on an APB slave.
 assumes latch and peripheral signals come from logic on mclk.
*/
// The APB interface to the registers and the register offsets were left to the implementer.
module pin_function_mux
  import pin_mux_pkg::*;
(
  input wire logic mclk,
  input wire logic reset_n,
  input wire apb_req_s apb_req,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] a_latch,
  input wire logic [7:0] b_latch,
  input wire logic [1:0] c_latch,
  input wire periph_out_s periph,
  output logic [7:0] pin_a_out,
  output logic [7:0] pin_a_periph,
  output logic [7:0] pin_a_release,
  output logic [7:0] pin_b_out,
  output logic [7:0] pin_b_periph,
  output logic [7:0] pin_b_release,
  output logic [1:0] pin_c_out,
  output logic [1:0] pin_c_periph,
  output logic [1:0] pin_c_release,
  output logic [1:0] port_e_low_drive_field,
  output logic [1:0] port_g_high_drive,
  output logic [1:0] port_g_low_drive,
  output logic [7:0] port_b_io_supply,
  output logic [3:0] port_g_io_supply
);

  // ****************************************
  // bus decode
  // ****************************************
  logic setup;
  logic access;
  logic hit;
  logic wr;
  logic [7:0] rdata_nxt;
  logic [31:0] prdata_r;
  logic [31:0] owner_word;

  logic [7:0] e_drive_r;
  logic [7:0] port_g_drive_level_r;
  logic [7:0] pad_supply_select_r;
  logic [7:0] func_sel_a_low_r;
  logic [7:0] func_sel_a_high_r;
  logic [7:0] func_sel_b_low_r;
  logic [7:0] func_sel_b_high_r;
  logic [7:0] func_sel_c_low_r;

  assign setup = apb_req.psel & ~apb_req.penable;
  assign access = apb_req.psel & apb_req.penable;
  assign wr = access & apb_req.pwrite & hit & apb_req.pstrb[0];
  // zero wait states: read data is caught in the setup cycle
  assign pready = 1'h1;
  assign pslverr = access & ~hit;
  assign prdata = prdata_r;

  assign owner_word = {14'h0, pin_c_periph, pin_b_periph,
                       pin_a_periph};

  always_comb begin
    hit = 1'h1;
    rdata_nxt = RST_ZERO;
    case (apb_req.paddr)
      A_E_DRIVE: rdata_nxt = e_drive_r & M_E_DRIVE;
      A_G_DRIVE: rdata_nxt = port_g_drive_level_r & M_G_DRIVE;
      A_PAD_SUP: rdata_nxt = pad_supply_select_r & M_PAD_SUP;
      A_SEL_A_LO: rdata_nxt = func_sel_a_low_r;
      A_SEL_A_HI: rdata_nxt = func_sel_a_high_r;
      A_SEL_B_LO: rdata_nxt = func_sel_b_low_r;
      A_SEL_B_HI: rdata_nxt = func_sel_b_high_r;
      A_SEL_C_LO: rdata_nxt = func_sel_c_low_r & M_SEL_C_LO;
      A_OWNER: rdata_nxt = RST_ZERO;
      default: hit = 1'h0;
    endcase
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      prdata_r <= 32'h0;
    end else if (setup) begin
      if (apb_req.paddr == A_OWNER) begin
        prdata_r <= owner_word;
      end else begin
        prdata_r <= {24'h0, rdata_nxt};
      end
    end
  end

  // ****************************************
  // configuration registers
  // ****************************************
  // unimplemented bits are never stored, so they cannot leak back
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      e_drive_r <= RST_ZERO;
      port_g_drive_level_r <= RST_ZERO;
      pad_supply_select_r <= RST_ZERO;
      func_sel_a_low_r <= RST_ZERO;
      func_sel_a_high_r <= RST_ZERO;
      func_sel_b_low_r <= RST_ZERO;
      func_sel_b_high_r <= RST_ZERO;
      func_sel_c_low_r <= RST_ZERO;
    end else if (wr) begin
      case (apb_req.paddr)
        A_E_DRIVE: e_drive_r <= apb_req.pwdata[7:0] & M_E_DRIVE;
        A_G_DRIVE:
          port_g_drive_level_r <= apb_req.pwdata[7:0] & M_G_DRIVE;
        A_PAD_SUP:
          pad_supply_select_r <= apb_req.pwdata[7:0] & M_PAD_SUP;
        A_SEL_A_LO: func_sel_a_low_r <= apb_req.pwdata[7:0] & M_FULL;
        A_SEL_A_HI: func_sel_a_high_r <= apb_req.pwdata[7:0] & M_FULL;
        A_SEL_B_LO: func_sel_b_low_r <= apb_req.pwdata[7:0] & M_FULL;
        A_SEL_B_HI: func_sel_b_high_r <= apb_req.pwdata[7:0] & M_FULL;
        A_SEL_C_LO:
          func_sel_c_low_r <= apb_req.pwdata[7:0] & M_SEL_C_LO;
        default: ;
      endcase
    end
  end

  // ****************************************
  // drive level and pad supply
  // ****************************************
  assign port_e_low_drive_field = e_drive_r[1:0];
  assign port_g_high_drive = port_g_drive_level_r[3:2];
  assign port_g_low_drive = port_g_drive_level_r[1:0];
  // only the upper bit of each field matters: 0x core, 1x io pin
  assign port_b_io_supply = {{4{pad_supply_select_r[PAD_B_HI_UP]}},
                             {4{pad_supply_select_r[PAD_B_LO_UP]}}};
  assign port_g_io_supply = {4{pad_supply_select_r[PAD_G_UP]}};

  // ****************************************
  // pin function mux
  // ****************************************
  // returns {data, peripheral owns pin, driver released}
  function automatic logic [2:0] pin_sel(input logic [1:0] code,
                                         input kinds_t kinds,
                                         input logic [3:0] psig,
                                         input logic lat);
    logic [1:0] k;
    k = kinds[{code, 1'h0} +: 2];
    case (k)
      K_PER: pin_sel = {psig[code], 2'h2};
      K_REL: pin_sel = 3'h1;
      default: pin_sel = {lat, 2'h0};
    endcase
  endfunction

  logic [15:0] sel_a;
  logic [15:0] sel_b;
  logic [3:0] sel_c;
  logic [3:0] psig_a [8];
  logic [3:0] psig_b [8];
  logic [3:0] psig_c [2];

  assign sel_a = {func_sel_a_high_r, func_sel_a_low_r};
  assign sel_b = {func_sel_b_high_r, func_sel_b_low_r};
  assign sel_c = func_sel_c_low_r[3:0];

  // bit n of each vector is the signal for selector code n
  assign psig_a[0] = {1'h0, periph.periodic_timer0_out, 2'h0};
  assign psig_a[1] = {2'h0, periph.periodic_timer0_inverted_out,
                      1'h0};
  assign psig_a[2] = 4'h0;
  assign psig_a[3] = 4'h0;
  assign psig_a[4] = 4'h0;
  assign psig_a[5] = {1'h0, periph.std_timer_inverted_out,
                      2'h0};
  assign psig_a[6] = {2'h0, periph.periodic_timer2_out, 1'h0};
  assign psig_a[7] = 4'h0;
  assign psig_b[0] = {1'h0, periph.serial_clock_out,
                      periph.periodic_timer1_out, 1'h0};
  assign psig_b[1] = {1'h0, periph.serial_sda_out,
                      periph.periodic_timer2_out, 1'h0};
  assign psig_b[2] = {1'h0, periph.serial_data_out, 2'h0};
  assign psig_b[3] = {1'h0, periph.serial_chip_select, 2'h0};
  assign psig_b[4] = {periph.second_spi_chip_select, 3'h0};
  assign psig_b[5] = {periph.second_spi_data_out, 3'h0};
  assign psig_b[6] = {periph.second_spi_clock, 3'h0};
  assign psig_b[7] = 4'h0;
  assign psig_c[0] = {1'h0, periph.periodic_timer1_out, 2'h0};
  assign psig_c[1] = 4'h0;

  // registered so pad outputs never glitch on selector decode
  for (genvar i = 0; i < 8; i++) begin : g_port_ab
    always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
        pin_a_out[i] <= 1'h0;
        pin_a_periph[i] <= 1'h0;
        pin_a_release[i] <= 1'h0;
      end else begin
        {pin_a_out[i], pin_a_periph[i], pin_a_release[i]} <=
          pin_sel(sel_a[2*i +: 2], KIND_A[i], psig_a[i],
                  a_latch[i]);
      end
    end
    always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
        pin_b_out[i] <= 1'h0;
        pin_b_periph[i] <= 1'h0;
        pin_b_release[i] <= 1'h0;
      end else begin
        {pin_b_out[i], pin_b_periph[i], pin_b_release[i]} <=
          pin_sel(sel_b[2*i +: 2], KIND_B[i], psig_b[i],
                  b_latch[i]);
      end
    end
  end

  for (genvar i = 0; i < 2; i++) begin : g_port_c
    always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
        pin_c_out[i] <= 1'h0;
        pin_c_periph[i] <= 1'h0;
        pin_c_release[i] <= 1'h0;
      end else begin
        {pin_c_out[i], pin_c_periph[i], pin_c_release[i]} <=
          pin_sel(sel_c[2*i +: 2], KIND_C[i], psig_c[i],
                  c_latch[i]);
      end
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!reset_n);

  property p_g_drive_read;
    setup && apb_req.paddr == A_G_DRIVE |=> prdata[7:4] == 4'h0;
  endproperty
  a_g_drive_read: assert property (p_g_drive_read)
    else $error("port g drive upper bits not zero");

  property p_pad_read;
    setup && apb_req.paddr == A_PAD_SUP |=> prdata[7:6] == 2'h0;
  endproperty
  a_pad_read: assert property (p_pad_read)
    else $error("pad supply bits 7..6 not zero");

  property p_c_read;
    setup && apb_req.paddr == A_SEL_C_LO |=> prdata[7:4] == 4'h0;
  endproperty
  a_c_read: assert property (p_c_read)
    else $error("port c selector upper bits not zero");

  property p_pad_switch;
    wr && apb_req.paddr == A_PAD_SUP && apb_req.pwdata[5:0] == 6'h2a
      |=> port_b_io_supply == 8'hff && port_g_io_supply == 4'hf;
  endproperty
  a_pad_switch: assert property (p_pad_switch)
    else $error("io supply not selected by upper bits");

  property p_pad_core;
    wr && apb_req.paddr == A_PAD_SUP && apb_req.pwdata[5:0] == 6'h15
      |=> port_b_io_supply == 8'h00 && port_g_io_supply == 4'h0;
  endproperty
  a_pad_core: assert property (p_pad_core)
    else $error("lower field bits changed supply");

  property p_drive_write;
    wr && apb_req.paddr == A_G_DRIVE
      |=> {port_g_high_drive, port_g_low_drive}
          == $past(apb_req.pwdata[3:0]);
  endproperty
  a_drive_write: assert property (p_drive_write)
    else $error("port g drive fields not written");

  property p_a3_release;
    wr && apb_req.paddr == A_SEL_A_LO && apb_req.pwdata[7:6] == 2'h2
      |=> ##1 pin_a_release[3] && !pin_a_periph[3];
  endproperty
  a_a3_release: assert property (p_a3_release)
    else $error("pin a3 not released for oscillator");

  property p_a1_timer;
    func_sel_a_low_r[3:2] == 2'h1
      |=> pin_a_periph[1] &&
          pin_a_out[1] == $past(periph.periodic_timer0_inverted_out);
  endproperty
  a_a1_timer: assert property (p_a1_timer)
    else $error("pin a1 not fed from timer0 inverted");

  property p_a2_gpio;
    func_sel_a_low_r[5:4] == 2'h2
      |=> !pin_a_periph[2] && pin_a_out[2] == $past(a_latch[2]);
  endproperty
  a_a2_gpio: assert property (p_a2_gpio)
    else $error("pin a2 code 10 not general io");

  property p_b0_sck;
    func_sel_b_low_r[1:0] == 2'h2
      |=> pin_b_out[0] == $past(periph.serial_clock_out);
  endproperty
  a_b0_sck: assert property (p_b0_sck)
    else $error("pin b0 not fed from serial clock");

  property p_b7_spi;
    func_sel_b_high_r[7:6] == 2'h3 |=> pin_b_release[7];
  endproperty
  a_b7_spi: assert property (p_b7_spi)
    else $error("pin b7 not released for spi data in");

  property p_a0_timer;
    func_sel_a_low_r[1:0] == 2'h2
      |=> pin_a_periph[0] &&
          pin_a_out[0] == $past(periph.periodic_timer0_out);
  endproperty
  a_a0_timer: assert property (p_a0_timer)
    else $error("pin a0 not fed from timer0");

  property p_a4_osc;
    func_sel_a_high_r[1:0] == 2'h2
      |=> pin_a_release[4] && !pin_a_periph[4];
  endproperty
  a_a4_osc: assert property (p_a4_osc)
    else $error("pin a4 not released for oscillator");

  property p_a6_timer;
    func_sel_a_high_r[5:4] == 2'h1
      |=> pin_a_periph[6] &&
          pin_a_out[6] == $past(periph.periodic_timer2_out);
  endproperty
  a_a6_timer: assert property (p_a6_timer)
    else $error("pin a6 not fed from timer2");

  property p_b4_spi;
    func_sel_b_high_r[1:0] == 2'h3
      |=> pin_b_periph[4] &&
          pin_b_out[4] == $past(periph.second_spi_chip_select);
  endproperty
  a_b4_spi: assert property (p_b4_spi)
    else $error("pin b4 not fed from spi chip select");

  property p_c1_analog;
    func_sel_c_low_r[3:2] == 2'h3
      |=> pin_c_release[1] && !pin_c_periph[1];
  endproperty
  a_c1_analog: assert property (p_c1_analog)
    else $error("pin c1 not released for analog");

  property p_reset_zero;
    disable iff (1'h0)
    !reset_n |-> pad_supply_select_r == RST_ZERO &&
                 sel_a == 16'h0 && sel_b == 16'h0 &&
                 port_g_drive_level_r == RST_ZERO;
  endproperty
  a_reset_zero: assert property (p_reset_zero)
    else $error("fields not zero in reset");

endmodule

// ---- sim/pin_function_mux_tb.sv ----
/*
 pin_function_mux_tb: self-checking bench, apb master and a model.
 assumes pin_mux_pkg and pin_function_mux are compiled first.
*/
module pin_function_mux_tb import pin_mux_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // signals and model state
  // ****************************************
  logic mclk = 1'b0;
  logic reset_n;
  apb_req_s apb_req = '0;
  logic [31:0] prdata;
  logic pready, pslverr;
  logic [7:0] a_latch = 8'h00, b_latch = 8'h00;
  logic [1:0] c_latch = 2'h0;
  periph_out_s periph = '0;
  logic [7:0] pin_a_out, pin_a_periph, pin_a_release;
  logic [7:0] pin_b_out, pin_b_periph, pin_b_release;
  logic [1:0] pin_c_out, pin_c_periph, pin_c_release;
  logic [1:0] e_drv, g_hi, g_lo;
  logic [7:0] b_sup;
  logic [3:0] g_sup;
  int failures = 0, checks_done = 0, cycles = 0, seed = 22342;
  logic [7:0] mreg [8];
  logic [17:0] x_out, x_per, x_rel;
  logic [31:0] x_rd;
  localparam logic [7:0] MASK [8] = '{M_E_DRIVE, M_G_DRIVE, M_PAD_SUP,
    M_FULL, M_FULL, M_FULL, M_FULL, M_SEL_C_LO};
  // per pin and code: -1 gpio, -2 released, else peripheral bit
  localparam int SRC [18][4] = '{
    '{-1, -1, 10, -2}, '{-1, 11, -2, -2},
    '{-1, -1, -1, -2}, '{-1, -1, -2, -2},
    '{-1, -1, -2, -2}, '{-1, -1, 7, -2},
    '{-1, 8, -2, -2}, '{-1, -1, -1, -2},
    '{-1, 9, 3, -2}, '{-1, 8, 4, -2},
    '{-1, -1, 5, -2}, '{-1, -1, 6, -2},
    '{-1, -1, -1, 0}, '{-1, -1, -1, 1},
    '{-1, -1, -1, 2}, '{-1, -1, -1, -2},
    '{-1, -1, 9, -2}, '{-1, -1, -1, -2}};

  pin_function_mux i_dut (
    .mclk(mclk), .reset_n(reset_n), .apb_req(apb_req),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .a_latch(a_latch), .b_latch(b_latch), .c_latch(c_latch),
    .periph(periph),
    .pin_a_out(pin_a_out), .pin_a_periph(pin_a_periph),
    .pin_a_release(pin_a_release), .pin_b_out(pin_b_out),
    .pin_b_periph(pin_b_periph), .pin_b_release(pin_b_release),
    .pin_c_out(pin_c_out), .pin_c_periph(pin_c_periph),
    .pin_c_release(pin_c_release), .port_e_low_drive_field(e_drv),
    .port_g_high_drive(g_hi), .port_g_low_drive(g_lo),
    .port_b_io_supply(b_sup), .port_g_io_supply(g_sup)
  );

  initial begin
    forever #2 mclk = ~mclk;
  end

  function automatic logic [31:0] rd_model(addr_t a);
    if (a == A_OWNER) return {14'h0, x_per};
    if (a < A_OWNER && a[1:0] == 2'h0) return {24'h0, mreg[a[4:2]]};
    return 32'h0;
  endfunction

  // model: pins use selectors from before this edge, like the pads
  always @(posedge mclk or negedge reset_n) begin
    int s;
    logic [1:0] c;
    logic [11:0] pv;
    logic [17:0] lat;
    pv = periph;
    lat = {c_latch, b_latch, a_latch};
    if (!reset_n) begin
      foreach (mreg[i]) mreg[i] = 8'h00;
      x_out = '0;
      x_per = '0;
      x_rel = '0;
    end else begin
      if (apb_req.psel && !apb_req.penable) x_rd = rd_model(apb_req.paddr);
      for (int p = 0; p < 18; p++) begin
        c = mreg[3 + p / 4][(p % 4) * 2 +: 2];
        s = SRC[p][c];
        x_out[p] = (s >= 0) ? pv[s] : (s == -1) ? lat[p] : 1'b0;
        x_per[p] = (s >= 0);
        x_rel[p] = (s == -2);
      end
      if (apb_req.psel && apb_req.penable && apb_req.pwrite &&
          apb_req.pstrb[0] && apb_req.paddr < A_OWNER &&
          apb_req.paddr[1:0] == 2'h0)
        mreg[apb_req.paddr[4:2]] = apb_req.pwdata[7:0] &
                                   MASK[apb_req.paddr[4:2]];
    end
  end

  // ****************************************
  // stimulus, checks and verdict
  // ****************************************
  always @(posedge mclk) begin
    logic [31:0] rv;
    rv = $random(seed);
    a_latch <= rv[7:0];
    b_latch <= rv[15:8];
    c_latch <= rv[17:16];
    rv = $random(seed);
    periph <= rv[11:0];
  end

  task automatic chk(logic [63:0] got, logic [63:0] exp, string what);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got,
               exp);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  always @(negedge mclk) begin
    chk({x_out, x_per, x_rel}, {pin_c_out, pin_b_out, pin_a_out,
        pin_c_periph, pin_b_periph, pin_a_periph, pin_c_release,
        pin_b_release, pin_a_release}, "pins");
    chk({e_drv, g_hi, g_lo, b_sup, g_sup}, {mreg[0][1:0], mreg[1][3:2],
        mreg[1][1:0], {4{mreg[2][PAD_B_HI_UP]}},
        {4{mreg[2][PAD_B_LO_UP]}}, {4{mreg[2][PAD_G_UP]}}},
        "config");
    cycles++;
    if (cycles == 20000) begin
      failures++;
      give_verdict();
    end
  end

  // one apb transfer; the master never assumes a wait count
  task automatic acc(logic w, addr_t a, logic [31:0] d, logic [3:0] st,
                     logic bad);
    logic ok, err;
    logic [31:0] q;
    @(posedge mclk);
    apb_req <= '{1'b1, 1'b0, w, a, d, st};
    @(posedge mclk);
    apb_req.penable <= 1'b1;
    // answer taken at the rising edge that samples pready high
    do begin
      @(posedge mclk);
      ok = pready;
      q = prdata;
      err = pslverr;
    end while (ok !== 1'b1);
    apb_req.psel <= 1'b0;
    apb_req.penable <= 1'b0;
    chk(err, bad, "slverr");
    if (!w && !bad) chk(q, x_rd, "rdata");
  endtask

  initial begin
    logic [31:0] rv;
    // x to 0 edge at time 0 so the async reset fires before any edge
    reset_n <= 1'b0;
    repeat (20) @(posedge mclk);
    reset_n <= 1'b1;
    for (int i = 0; i <= 8; i++) acc(0, addr_t'(i * 4), 0, 4'hf, 0);
    // all ones shows which bits exist
    for (int i = 0; i < 8; i++) begin
      acc(1, addr_t'(i * 4), 32'hffffffff, 4'hf, 0);
      acc(0, addr_t'(i * 4), 0, 4'hf, 0);
    end
    // supply pin function sits outside this block
    acc(1, A_PAD_SUP, 32'h2a, 4'hf, 0);
    acc(1, A_PAD_SUP, 32'h15, 4'hf, 0);
    // selectors set before peripherals are used
    // input steering and direction bits live outside
    // every code on every pin, owner status read per code
    for (int c = 0; c < 4; c++) begin
      for (int i = 3; i < 8; i++) acc(1, addr_t'(i * 4),
          {24'h0, {4{c[1:0]}}}, 4'hf, 0);
      repeat (4) @(posedge mclk);
      acc(0, A_OWNER, 0, 4'hf, 0);
    end
    // refused writes leave the registers alone
    acc(1, A_SEL_A_LO, 32'h55, 4'he, 0);
    acc(1, A_OWNER, 32'hff, 4'hf, 0);
    acc(1, 12'h024, 32'hff, 4'hf, 1);
    acc(0, 12'hffc, 0, 4'hf, 1);
    acc(0, A_SEL_A_LO, 0, 4'hf, 0);
    acc(0, A_OWNER, 0, 4'hf, 0);
    repeat (300) begin
      rv = $random(seed);
      acc(rv[0], addr_t'(rv[3:1] * 4), $random(seed), 4'hf, 0);
    end
    // second reset in mid-run clears every field
    @(posedge mclk);
    reset_n <= 1'b0;
    repeat (3) @(posedge mclk);
    reset_n <= 1'b1;
    for (int i = 0; i <= 8; i++) acc(0, addr_t'(i * 4), 0, 4'hf, 0);
    give_verdict();
  end
endmodule
